/* File: hw/rom_pin_ctrl.sv */
// Boot-ROM serial pin controller: chip select, serial clock, data pins,
// speed strap and low-power pin states, with a byte request port.
// Assumes link_clk_in is a free-running fast reference unrelated to
// clk_in, and that reset_n_in is asynchronous and active low.
`timescale 1ns/1ps
module rom_pin_ctrl
    import rom_pin_pkg::*;
(
    // Clocks and reset
    input  wire logic     clk_in,
    input  wire logic     reset_n_in,
    input  wire logic     link_clk_in,
    // Byte requests
    input  wire logic     req_valid_in,
    input  wire rom_req_s req_in,
    output logic          req_ready_out,
    // Byte answers
    output logic          rsp_valid_out,
    output rom_rsp_s      rsp_out,
    // Modes and I2C line requests
    input  wire logic     i2c_mode_in,
    input  wire logic     power_down_in,
    input  wire logic     suspend_in,
    input  wire logic     i2c_scl_low_in,
    input  wire logic     i2c_sda_low_in,
    // Status
    output logic          rom_speed_out,
    output logic          strap_valid_out,
    output logic          i2c_scl_out,
    output logic          i2c_sda_out,
    // ROM pins
    output logic          rom_cs_n_out,
    output logic          rom_clk_out,
    output logic          rom_clk_oe_out,
    input  wire logic     rom_clk_pin_in,
    output logic          rom_dout_out,
    output logic          rom_dout_oe_out,
    input  wire logic     rom_dout_pin_in,
    output logic          rom_strap_pd_out,
    input  wire logic     rom_data_in
);

    // ========================================================
    // System-domain request side
    rom_req_s          req_hold_reg;
    logic              req_tgl_reg;
    logic              done_seen_reg;
    logic              done_s;
    logic              done_evt;
    logic              req_take;
    // Link-domain signals
    logic              link_rst_n;
    link_ctl_s         ctl_s;
    logic              req_s;
    logic              req_seen_reg;
    logic              req_evt;
    logic              strap_s;
    logic              data_s;
    strap_state_e      strap_state_reg;
    logic [1:0]        settle_reg;
    logic              strap_done;
    logic              rom_speed_reg;
    logic              block;
    logic              start;
    logic              sh_busy;
    logic              sh_done;
    logic              sh_sck;
    logic              sh_mosi;
    logic [BYTE_W-1:0] sh_rx;
    logic              last_reg;
    logic              done_tgl_reg;
    rom_rsp_s          rsp_hold_reg;
    logic              rom_cs_n_reg;
    logic              rom_clk_reg;
    logic              rom_clk_oe_reg;
    logic              rom_dout_reg;
    logic              rom_dout_oe_reg;
    logic              pd_reg;

    assign req_take = req_valid_in && req_ready_out;
    assign done_evt = (done_s != done_seen_reg);

    // Take a request and hand it over by toggle; the held word stays
    // still until the answer returns, so it crosses safely
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_ready_out <= 1'b1;
            req_hold_reg  <= '0;
            req_tgl_reg   <= 1'b0;
        end else if (req_take) begin
            req_ready_out <= 1'b0;
            req_hold_reg  <= req_in;
            req_tgl_reg   <= ~req_tgl_reg;
        end else if (done_evt) begin
            req_ready_out <= 1'b1;
        end
    end

    // Answer pulse; the link holds rsp_hold_reg since its toggle flipped
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_seen_reg <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_out       <= '0;
        end else begin
            done_seen_reg <= done_s;
            rsp_valid_out <= done_evt;
            if (done_evt) begin
                rsp_out <= rsp_hold_reg;
            end
        end
    end

    // ========================================================
    // Crossings
    // Link reset: asserted at once, released on the link clock
    rom_sync2 #(.WIDTH(1)) u_link_rst (
        .clk_in     (link_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (1'b1),
        .sync_out   (link_rst_n)
    );

    rom_sync2 #(.WIDTH(1)) u_done_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (done_tgl_reg),
        .sync_out   (done_s)
    );

    rom_sync2 #(.WIDTH(STAT_W)) u_stat_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({strap_done, rom_speed_reg}),
        .sync_out   ({strap_valid_out, rom_speed_out})
    );

    rom_sync2 #(.WIDTH(PIN_RB_W)) u_pin_rb (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({rom_clk_pin_in, rom_dout_pin_in}),
        .sync_out   ({i2c_scl_out, i2c_sda_out})
    );

    rom_sync2 #(.WIDTH(CTL_W)) u_ctl_sync (
        .clk_in     (link_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({power_down_in, suspend_in, i2c_mode_in,
                      i2c_scl_low_in, i2c_sda_low_in}),
        .sync_out   (ctl_s)
    );

    rom_sync2 #(.WIDTH(3)) u_link_in (
        .clk_in     (link_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({req_tgl_reg, rom_dout_pin_in, rom_data_in}),
        .sync_out   ({req_s, strap_s, data_s})
    );

    // ========================================================
    // Speed strap
    assign strap_done = (strap_state_reg == STRAP_DONE);

    // latch strap after release
    // Wait for the pin synchroniser to carry a post-reset level
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            strap_state_reg <= STRAP_WAIT;
            settle_reg      <= '0;
            rom_speed_reg   <= 1'b0;
            pd_reg          <= 1'b1;
        end else begin
            case (strap_state_reg)
                STRAP_WAIT: begin
                    if (settle_reg == STRAP_SETTLE_CYC) begin
                        strap_state_reg <= STRAP_DONE;
                        rom_speed_reg   <= strap_s;
                        pd_reg          <= 1'b0;
                    end else begin
                        settle_reg <= settle_reg + 1'b1;
                    end
                end
                STRAP_DONE: strap_state_reg <= STRAP_DONE;
                default:    strap_state_reg <= STRAP_WAIT;
            endcase
        end
    end

    // ========================================================
    // Transfer control
    assign req_evt = (req_s != req_seen_reg);
    assign block   = !strap_done || ctl_s.power_down || ctl_s.suspend
                     || ctl_s.i2c_mode;
    assign start   = req_evt && !block;

    rom_spi_shifter u_shifter (
        .clk_in     (link_clk_in),
        .reset_n_in (link_rst_n),
        .start_in   (start),
        .abort_in   (block),
        .fast_in    (rom_speed_reg),
        .tx_in      (req_hold_reg.data),
        .miso_in    (data_s),
        .sck_out    (sh_sck),
        .mosi_out   (sh_mosi),
        .busy_out   (sh_busy),
        .done_out   (sh_done),
        .rx_out     (sh_rx)
    );

    // Every request gets one answer: data, or refused when blocked
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_seen_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
            rsp_hold_reg <= '0;
            last_reg     <= 1'b0;
        end else begin
            req_seen_reg <= req_s;
            if (start) begin
                last_reg <= req_hold_reg.last;
            end
            if (req_evt && block) begin
                rsp_hold_reg <= '{data: '0, refused: 1'b1};
                done_tgl_reg <= ~done_tgl_reg;
            end else if (sh_busy && block) begin
                rsp_hold_reg <= '{data: '0, refused: 1'b1};
                done_tgl_reg <= ~done_tgl_reg;
            end else if (sh_done) begin
                rsp_hold_reg <= '{data: sh_rx, refused: 1'b0};
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    // Chip select; stays low between bytes of one frame
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rom_cs_n_reg <= 1'b1;
        end else if (block) begin
            rom_cs_n_reg <= 1'b1;
        end else if (start) begin
            rom_cs_n_reg <= 1'b0;
        end else if (sh_done && last_reg) begin
            rom_cs_n_reg <= 1'b1;
        end
    end

    // ========================================================
    // Pin drivers
    // clock pin use
    // Reset forces a driven low clock; I2C mode is open drain
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rom_clk_reg    <= 1'b0;
            rom_clk_oe_reg <= 1'b1;
        end else if (strap_done && ctl_s.i2c_mode) begin
            rom_clk_reg    <= 1'b0;
            rom_clk_oe_reg <= ctl_s.scl_low;
        end else begin
            rom_clk_reg    <= strap_done && sh_sck;
            rom_clk_oe_reg <= 1'b1;
        end
    end

    // data-out pin use
    // Suspend ranks above I2C so the strap-chosen level always wins
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rom_dout_reg    <= 1'b0;
            rom_dout_oe_reg <= 1'b0;
        end else if (!strap_done) begin
            rom_dout_reg    <= 1'b0;
            rom_dout_oe_reg <= 1'b0;
        end else if (ctl_s.suspend) begin
            rom_dout_reg    <= 1'b0;
            rom_dout_oe_reg <= !rom_speed_reg;
        end else if (ctl_s.i2c_mode) begin
            rom_dout_reg    <= 1'b0;
            rom_dout_oe_reg <= ctl_s.sda_low;
        end else begin
            rom_dout_reg    <= sh_mosi;
            rom_dout_oe_reg <= 1'b1;
        end
    end

    assign rom_cs_n_out     = rom_cs_n_reg;
    assign rom_clk_out      = rom_clk_reg;
    assign rom_clk_oe_out   = rom_clk_oe_reg;
    assign rom_dout_out     = rom_dout_reg;
    assign rom_dout_oe_out  = rom_dout_oe_reg;
    assign rom_strap_pd_out = pd_reg;

    // ========================================================
    // Checks
    property p_cs_select;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        start |=> !rom_cs_n_reg;
    endproperty
    a_cs_select: assert property (p_cs_select)
        else $error("chip select not low after transfer start");

    property p_cs_pd;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        ctl_s.power_down |=> rom_cs_n_reg;
    endproperty
    a_cs_pd: assert property (p_cs_pd)
        else $error("chip select low during power down");

    property p_clk_low;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        !strap_done |-> (!rom_clk_reg && rom_clk_oe_reg);
    endproperty
    a_clk_low: assert property (p_clk_low)
        else $error("serial clock not driven low before strap latch");

    property p_scl;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (strap_done && ctl_s.i2c_mode)
            |=> (!rom_clk_reg && rom_clk_oe_reg == $past(ctl_s.scl_low));
    endproperty
    a_scl: assert property (p_scl)
        else $error("clock pin not following I2C clock request");

    property p_sda;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (strap_done && ctl_s.i2c_mode && !ctl_s.suspend)
            |=> (!rom_dout_reg && rom_dout_oe_reg == $past(ctl_s.sda_low));
    endproperty
    a_sda: assert property (p_sda)
        else $error("data pin not following I2C data request");

    property p_strap_float;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        !strap_done |-> (pd_reg && !rom_dout_oe_reg);
    endproperty
    a_strap_float: assert property (p_strap_float)
        else $error("strap pin driven or pull-down off before latch");

    property p_strap_latch;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        $rose(strap_done) |-> (rom_speed_reg == $past(strap_s) && !pd_reg);
    endproperty
    a_strap_latch: assert property (p_strap_latch)
        else $error("strap level not latched or pull-down still on");

    property p_susp_fast;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (strap_done && ctl_s.suspend && rom_speed_reg) |=> !rom_dout_oe_reg;
    endproperty
    a_susp_fast: assert property (p_susp_fast)
        else $error("data pin driven in suspend with fast strap");

    property p_susp_slow;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (strap_done && ctl_s.suspend && !rom_speed_reg)
            |=> (rom_dout_oe_reg && !rom_dout_reg);
    endproperty
    a_susp_slow: assert property (p_susp_slow)
        else $error("data pin not driven low in suspend with slow strap");

    property p_cs_strap;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        !strap_done |-> rom_cs_n_reg;
    endproperty
    a_cs_strap: assert property (p_cs_strap)
        else $error("chip select low before strap latched");

endmodule // rom_pin_ctrl

/* File: hw/rom_spi_shifter.sv */
// Byte shifter for the serial ROM, mode 0, MSB first, on the link clock.
// Assumes miso_in is already synchronised and fast_in is stable.
`timescale 1ns/1ps
module rom_spi_shifter
    import rom_pin_pkg::*;
(
    // Link clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    // Control
    input  wire logic              start_in,
    input  wire logic              abort_in,
    input  wire logic              fast_in,
    input  wire logic [BYTE_W-1:0] tx_in,
    input  wire logic              miso_in,
    // Serial side and result
    output logic                   sck_out,
    output logic                   mosi_out,
    output logic                   busy_out,
    output logic                   done_out,
    output logic      [BYTE_W-1:0] rx_out
);

    shift_state_e         state_reg;
    logic [HALF_W-1:0]    cnt_reg;
    logic [BIT_IDX_W-1:0] bit_reg;
    logic [BYTE_W-1:0]    sh_reg;
    logic [HALF_W-1:0]    half_cnt;
    // Data for a fall is taken this many link cycles later: one for the
    // pin register, two for the data-in synchroniser
    localparam int SAMPLE_DLY = 3;
    localparam logic [SAMPLE_DLY-1:0] LAST_TAKE =
        {1'b1, {(SAMPLE_DLY-1){1'b0}}};
    logic [SAMPLE_DLY-1:0] fall_pipe_reg;
    logic                  tail_reg;
    logic                  fall_now;

    assign half_cnt = fast_in ? HALF_W'(HALF_FAST_CYC - 1)
                              : HALF_W'(HALF_SLOW_CYC - 1);
    assign busy_out = (state_reg == SH_SHIFT);
    assign fall_now = busy_out && !abort_in && !tail_reg
                      && (cnt_reg == half_cnt) && sck_out;

    // Shift sequence; sampling right at the fall would read the data line
    // from three cycles before the pin fell, so each fall is delayed first
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg     <= SH_IDLE;
            cnt_reg       <= '0;
            bit_reg       <= '0;
            sh_reg        <= '0;
            rx_out        <= '0;
            sck_out       <= 1'b0;
            mosi_out      <= 1'b0;
            done_out      <= 1'b0;
            fall_pipe_reg <= '0;
            tail_reg      <= 1'b0;
        end else begin
            done_out      <= 1'b0;
            fall_pipe_reg <= {fall_pipe_reg[SAMPLE_DLY-2:0], fall_now};
            if (fall_pipe_reg[SAMPLE_DLY-1]) begin
                rx_out <= {rx_out[BYTE_W-2:0], miso_in};
            end
            case (state_reg)
                SH_IDLE: begin
                    sck_out <= 1'b0;
                    if (start_in && !abort_in) begin
                        state_reg <= SH_SHIFT;
                        sh_reg    <= tx_in;
                        mosi_out  <= tx_in[BYTE_W-1];
                        bit_reg   <= BIT_IDX_W'(BYTE_W - 1);
                        cnt_reg   <= '0;
                    end
                end
                SH_SHIFT: begin
                    if (abort_in) begin
                        state_reg <= SH_IDLE;
                        sck_out   <= 1'b0;
                        tail_reg  <= 1'b0;
                    end else if (tail_reg) begin
                        // Done once the last fall's data is taken
                        if (fall_pipe_reg == LAST_TAKE) begin
                            state_reg <= SH_IDLE;
                            tail_reg  <= 1'b0;
                            done_out  <= 1'b1;
                        end
                    end else if (cnt_reg == half_cnt) begin
                        cnt_reg <= '0;
                        sck_out <= ~sck_out;
                        if (sck_out) begin
                            if (bit_reg == '0) begin
                                tail_reg <= 1'b1;
                            end else begin
                                bit_reg  <= bit_reg - 1'b1;
                                sh_reg   <= {sh_reg[BYTE_W-2:0], 1'b0};
                                mosi_out <= sh_reg[BYTE_W-2];
                            end
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= SH_IDLE;
            endcase
        end
    end

    property p_sck_hold;
        @(posedge clk_in) disable iff (!reset_n_in)
        (busy_out && !abort_in && cnt_reg != half_cnt) |=> $stable(sck_out);
    endproperty
    a_sck_hold: assert property (p_sck_hold)
        else $error("serial clock changed before half period ended");

    property p_sck_flip;
        @(posedge clk_in) disable iff (!reset_n_in)
        (busy_out && !abort_in && !tail_reg && cnt_reg == half_cnt)
            |=> (sck_out != $past(sck_out));
    endproperty
    a_sck_flip: assert property (p_sck_flip)
        else $error("serial clock did not toggle at half period");

endmodule // rom_spi_shifter

/* File: hw/rom_sync2.sv */
// Two-flop synchroniser for independent level signals.
// Assumes each bit is a level that holds long enough to be seen.
`timescale 1ns/1ps
module rom_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset of the receiving domain
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Level from another domain or a pin
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second, to let metastability settle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // rom_sync2

/* File: shared/rom_pin_pkg.sv */
// Shared constants and types for the boot-ROM serial pin controller.
// Assumes the system clock runs at CLK_MHZ and the link clock at
// LINK_CLK_MHZ, a fast reference from which the serial clock is divided.
package rom_pin_pkg;

    // ========================================================
    // Clock rates and timing
    localparam int CLK_MHZ        = 10;
    localparam int LINK_CLK_MHZ   = 120;
    localparam int SPEED_SLOW_MHZ = 30;
    localparam int SPEED_FAST_MHZ = 60;
    // Half serial period in link cycles; a longest time rounds down
    localparam int HALF_SLOW_CYC  = LINK_CLK_MHZ / (2 * SPEED_SLOW_MHZ);
    localparam int HALF_FAST_CYC  = LINK_CLK_MHZ / (2 * SPEED_FAST_MHZ);
    localparam int HALF_W         = 4;
    // Least reset pulse from the system, a least time rounds up
    localparam int RESET_MIN_NS   = 1000;
    localparam int RESET_MIN_CYC  = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

    // ========================================================
    // Data widths and strap handling
    localparam int BYTE_W         = 8;
    localparam int BIT_IDX_W      = 3;
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;
    localparam int CTL_W          = 5;
    localparam int PIN_RB_W       = 2;
    localparam int STAT_W         = 2;

    // ========================================================
    // Carriers and states
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic              last;
    } rom_req_s;

    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic              refused;
    } rom_rsp_s;

    typedef struct packed {
        logic power_down;
        logic suspend;
        logic i2c_mode;
        logic scl_low;
        logic sda_low;
    } link_ctl_s;

    typedef enum logic [0:0] {STRAP_WAIT, STRAP_DONE} strap_state_e;
    typedef enum logic [0:0] {SH_IDLE, SH_SHIFT} shift_state_e;

endpackage

/* File: test/rom_flash_model.sv */
// Serial ROM model: shifts a fixed byte out and collects the sent byte.
// Assumes mode 0 on the pins and resolves pin levels for the bench.
`timescale 1ns/1ps
module rom_flash_model #(
    parameter logic [7:0] ROM_BYTE = 8'ha5
) (
    // Link clock and strap resistor
    input  wire logic       link_clk_in,
    input  wire logic       strap_pu_in,
    // Pins from the controller
    input  wire logic       cs_n_in,
    input  wire logic       clk_in,
    input  wire logic       clk_oe_in,
    input  wire logic       dout_in,
    input  wire logic       dout_oe_in,
    input  wire logic       pd_in,
    // Resolved pins and observations
    output logic            clk_pin_out,
    output logic            dout_pin_out,
    output logic            data_out,
    output logic [7:0]      got_out,
    output int              high_cyc_out
);
    logic [7:0] shift_reg;
    logic       clk_q;
    int         hi_cnt;
    // ==========================================================
    // Pin levels: clock line pulled up, released data-out at strap pull-up or pull-down, else floats
    assign clk_pin_out = clk_oe_in ? clk_in : 1'b1;
    assign dout_pin_out = dout_oe_in ? dout_in :
                          (strap_pu_in ? 1'b1 : (pd_in ? 1'b0 : ~dout_in));
    // read data driven
    // Unselected line sits at its pull-down level
    assign data_out = cs_n_in ? 1'b0 : shift_reg[7];
    // ==========================================================
    // Next bit shown on the link edge that sees each fall, as in mode 0
    always @(posedge link_clk_in) begin
        clk_q <= clk_in;
        hi_cnt <= clk_in ? hi_cnt + 1 : 0;
        if (clk_q && !clk_in) begin
            high_cyc_out <= hi_cnt;
        end
        if (!clk_q && clk_in) begin
            got_out <= {got_out[6:0], dout_in};
        end
        if (cs_n_in) begin
            shift_reg <= ROM_BYTE;
        end else if (clk_q && !clk_in) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
        end
    end
endmodule // rom_flash_model

/* File: test/testbench.sv */
// Bench for the boot-ROM pin controller with a serial ROM model.
// Assumes the design checks its own assertions internally.
`timescale 1ns/1ps
module testbench;
    import rom_pin_pkg::*;
    logic clk_in = 0, link_clk = 0, reset_n_in = 0, strap_pu = 0;
    logic req_valid_in = 0, i2c_mode_in = 0, power_down_in = 0;
    logic suspend_in = 0, scl_low = 0, sda_low = 0;
    rom_req_s req_in = '0;
    rom_rsp_s rsp_out;
    rom_rsp_s exp_q[$];
    logic rdy, rsp_v, spd, sv, scl, sda, cs_n, sck, sck_oe, sck_pin;
    logic dout, dout_oe, dout_pin, pd, din;
    logic [7:0] got, tx;
    int hi_cyc, err_total = 0, tests_run = 0, seed = 3, n;
    // ==========================================================
    // Clocks, unrelated in phase
    initial forever #50 clk_in = ~clk_in;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    rom_pin_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .link_clk_in(link_clk), .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(rdy), .rsp_valid_out(rsp_v), .rsp_out(rsp_out),
        .i2c_mode_in(i2c_mode_in), .power_down_in(power_down_in),
        .suspend_in(suspend_in), .i2c_scl_low_in(scl_low),
        .i2c_sda_low_in(sda_low), .rom_speed_out(spd), .strap_valid_out(sv),
        .i2c_scl_out(scl), .i2c_sda_out(sda), .rom_cs_n_out(cs_n),
        .rom_clk_out(sck), .rom_clk_oe_out(sck_oe), .rom_clk_pin_in(sck_pin),
        .rom_dout_out(dout), .rom_dout_oe_out(dout_oe),
        .rom_dout_pin_in(dout_pin), .rom_strap_pd_out(pd), .rom_data_in(din));
    rom_flash_model i_rom (.link_clk_in(link_clk), .strap_pu_in(strap_pu),
        .cs_n_in(cs_n), .clk_in(sck), .clk_oe_in(sck_oe), .dout_in(dout),
        .dout_oe_in(dout_oe), .pd_in(pd), .clk_pin_out(sck_pin),
        .dout_pin_out(dout_pin), .data_out(din), .got_out(got),
        .high_cyc_out(hi_cyc));
    // ==========================================================
    task automatic check(input logic [8:0] seen, input logic [8:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Request with last set; bounded waits for take and answer
    task automatic send(input logic [7:0] d, input rom_rsp_s e);
        exp_q.push_back(e);
        @(negedge clk_in);
        req_valid_in = 1'b1;
        req_in = '{d, 1'b1};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        @(negedge clk_in);
        req_valid_in = 1'b0;
        while (exp_q.size() > 0 && n < 300) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 300) begin
            err_total++;
            give_verdict();
        end
    endtask
    // Answers checked oldest note first
    always @(posedge clk_in) begin
        if (rsp_v === 1'b1 && exp_q.size() > 0) begin
            #1 check(rsp_out, exp_q.pop_front(), "answer");
        end
    end
    // ==========================================================
    initial begin
        for (int s = 0; s < 2; s++) begin
            strap_pu = s[0];
            reset_n_in = 1'b0;
            repeat (12) @(negedge clk_in);
            check({cs_n, sck, pd, dout_oe}, 9'h00a, "reset pins");
            reset_n_in = 1'b1;
            n = 0;
            while (sv !== 1'b1 && n < 50) begin
                @(negedge clk_in);
                n++;
            end
            if (n >= 50) begin
                err_total++;
                give_verdict();
            end
            check({spd, pd}, {s[0], 1'b0}, "strap");
            tx = 8'($random(seed));
            send(tx, '{8'ha5, 1'b0});
            check(got, tx, "sent byte");
            check(hi_cyc, s ? HALF_FAST_CYC : HALF_SLOW_CYC, "half");
            suspend_in = 1'b1;
            repeat (4) @(negedge clk_in);
            check({dout_oe, s ? 1'b0 : dout}, s ? 0 : 2, "suspend");
            send(tx, '{8'h00, 1'b1});
            suspend_in = 1'b0;
            power_down_in = 1'b1;
            repeat (4) @(negedge clk_in);
            check(cs_n, 1'b1, "power down cs");
            send(tx, '{8'h00, 1'b1});
            power_down_in = 1'b0;
            i2c_mode_in = 1'b1;
            scl_low = 1'b1;
            sda_low = tx[0];
            repeat (6) @(negedge clk_in);
            check({sck_oe, sck, dout_oe, dout, scl, sda},
                  {2'h2, tx[0], 2'h0, ~tx[0]}, "i2c");
            scl_low = 1'b0;
            repeat (6) @(negedge clk_in);
            check({sck_oe, scl}, 2'h1, "i2c release");
            i2c_mode_in = 1'b0;
            $display("test %0d done", s);
        end
        give_verdict();
    end
endmodule // testbench
